/* board_switch_regs.vh */
// Register map, field positions and reset values of the switch port block.
`ifndef BOARD_SWITCH_REGS_VH
`define BOARD_SWITCH_REGS_VH

`define ADDR_W            12
`define GEN_SW_OFS        12'h000
`define HW_SW_OFS         12'h004
`define ROUTE_STAT_OFS    12'h008
`define BOARD_CTRL_OFS    12'h00C

`define SEL_NONE          3'h0
`define SEL_GEN           3'h1
`define SEL_HW            3'h2
`define SEL_STAT          3'h3
`define SEL_CTRL          3'h4

`define HW_MEM_WIDTH      0
`define HW_BUS_CLK        1
`define HW_PLL_MUL        2
`define HW_TEST           3
`define HW_ROM_KIND0      4
`define HW_ROM_KIND1      5
`define HW_ROM_SPLIT      6
`define HW_ROM_LOWER      7

`define STAT_IRQ_LSB      0
`define STAT_DMA_LSB      8
`define STAT_TEST_BIT     12
`define STAT_PAIR_BIT     13
`define CTRL_SOFT_RST     0

`define DMA_REQ2_SW       0
`define DMA_ACK2_SW       1
`define DMA_REQ3_SW       2
`define DMA_ACK3_SW       3

`define SYNC_W            29
`define SYNC_RST          29'h0000_0000
`define DATA_ZERO         32'h0000_0000
`define BYTE_ZERO         8'h00
`define NIB_ZERO          4'h0
`define DMA_IDLE_N        2'h3

`endif

/* switch_sync.v */
// Two-flop synchroniser for the board switch and button levels.
`timescale 1ns/1ps
module switch_sync #(
   parameter WIDTH = 29
) (
   input  wire             I_CLK,
   input  wire             I_RST,
   input  wire [WIDTH-1:0] I_ASYNC,
   output reg  [WIDTH-1:0] O_SYNC
);
`include "board_switch_regs.vh"

   reg [WIDTH-1:0] stage1;

   // The first stage feeds only the second, so no logic sees a metastable bit.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         stage1 <= `SYNC_RST;
         O_SYNC <= `SYNC_RST;
      end else begin
         stage1 <= I_ASYNC;
         O_SYNC <= stage1;
      end
   end
endmodule // switch_sync

/* board_config_switch_port.v */
// Board switch ports, hardware settings and interrupt and DMA routing.
//
// Contract
// RULE1 - Reset button resets whole board including processor.
// RULE2 - General port reads off as 1, on as 0.
// RULE3 - All eight setting bits readable, inverted polarity.
// RULE4 - Setting bit 1 selects 32 or 16-bit bus.
// RULE5 - Setting bit 2 reports bus clock range.
// RULE6 - Setting bit 3 drives PLL multiplier pin.
// RULE7 - Setting bits 6 and 5 encode ROM kind.
// RULE8 - Setting bit 7 chooses split or contiguous ROM.
// RULE9 - Setting bit 8 picks bank while split.
// RULE10 - Interrupt switch on connects source, off cuts.
// RULE11 - Operator keeps first interrupt switch on with monitor.
// RULE12 - DMA switch on connects processor and extension line.
// RULE13 - Operator sets DMA switch pairs alike.
// RULE14 - Switch levels synchronised before software reads them.
// RULE15 - Test setting bit must stay off; else unsupported.
`timescale 1ns/1ps
module board_config_switch_port (
   input  wire        I_CLK,
   input  wire        I_RST,
   input  wire        I_RESET_BUTTON,
   input  wire [7:0]  I_GENERAL_SWITCH_ON,
   input  wire [7:0]  I_HARDWARE_SETTING_SWITCH_ON,
   input  wire [7:0]  I_INTERRUPT_ROUTING_SWITCH_ON,
   input  wire [3:0]  I_DMA_ROUTING_SWITCH_ON,
   input  wire        I_PSEL,
   input  wire        I_PENABLE,
   input  wire        I_PWRITE,
   input  wire [11:0] I_PADDR,
   input  wire [31:0] I_PWDATA,
   output wire        O_PREADY,
   output wire        O_PSLVERR,
   output reg  [31:0] O_PRDATA,
   output reg         O_BOARD_RESET,
   output reg         O_MEMORY_WIDTH_SELECT,
   output reg         O_BUS_CLOCK_RANGE_SELECT,
   output reg         O_PLL_MULTIPLIER_SELECT,
   output reg         O_ROM_KIND_BIT0,
   output reg         O_ROM_KIND_BIT1,
   output reg         O_ROM_BANK_SPLIT_CONTROL,
   output reg         O_ROM_LOWER_HALF_SELECT,
   output reg         O_CONFIG_UNSUPPORTED,
   input  wire [7:0]  I_IRQ_SOURCE,
   output reg  [7:0]  O_IRQ_INPUT,
   output reg  [7:0]  O_IRQ_INPUT_OE,
   input  wire        I_EXPANSION_DMA_REQUEST0_N,
   input  wire        I_EXPANSION_DMA_REQUEST1_N,
   output reg         O_DMA_REQUEST_TWO_N,
   output reg         O_DMA_REQUEST_TWO_N_OE,
   output reg         O_DMA_REQUEST_THREE_N,
   output reg         O_DMA_REQUEST_THREE_N_OE,
   input  wire        I_DMA_ACK_TWO_N,
   input  wire        I_DMA_ACK_THREE_N,
   output reg  [1:0]  O_EXPANSION_DMA_ACK_N,
   output reg  [1:0]  O_EXPANSION_DMA_ACK_N_OE
);
`include "board_switch_regs.vh"

   wire [`SYNC_W-1:0] sync_in;
   wire [`SYNC_W-1:0] sync_out;
   wire [7:0]         gen_on;
   wire [7:0]         hw_on;
   wire [7:0]         irq_on;
   wire [3:0]         dma_on;
   wire               button;
   wire               setup;
   wire               access;
   wire [2:0]         acc_sel;
   reg                soft_reset;
   reg  [31:0]        next_rdata;

   assign sync_in = {I_RESET_BUTTON, I_DMA_ROUTING_SWITCH_ON,
                     I_INTERRUPT_ROUTING_SWITCH_ON,
                     I_HARDWARE_SETTING_SWITCH_ON, I_GENERAL_SWITCH_ON};

   // Every switch passes the synchroniser before anything reads it.
   // The button shares this path, so a press costs three clocks of latency.
   switch_sync #(
      .WIDTH (`SYNC_W)
   ) u_sync (
      .I_CLK   (I_CLK),
      .I_RST   (I_RST),
      .I_ASYNC (sync_in),
      .O_SYNC  (sync_out)
   ); // RULE14

   assign gen_on = sync_out[7:0];
   assign hw_on  = sync_out[15:8];
   assign irq_on = sync_out[23:16];
   assign dma_on = sync_out[27:24];
   assign button = sync_out[28];

   // Shared address decode for the read and write paths.
   // Only whole-word offsets decode; anything else is refused.
   function [2:0] decode;
      input [11:0] addr;
      begin
         case (addr)
            `GEN_SW_OFS:     decode = `SEL_GEN;
            `HW_SW_OFS:      decode = `SEL_HW;
            `ROUTE_STAT_OFS: decode = `SEL_STAT;
            `BOARD_CTRL_OFS: decode = `SEL_CTRL;
            default:         decode = `SEL_NONE;
         endcase
      end
   endfunction

   assign setup     = I_PSEL & ~I_PENABLE;
   assign access    = I_PSEL & I_PENABLE;
   assign acc_sel   = decode(I_PADDR);
   // Every port answers at once, so no wait state is ever inserted.
   assign O_PREADY  = 1'b1;
   // Reads of the control word return zero without an error.
   // Unmapped addresses and writes to read-only ports answer with an error.
   assign O_PSLVERR = access & ((acc_sel == `SEL_NONE) |
                      (I_PWRITE & (acc_sel != `SEL_CTRL)));

   // Read data is captured in the setup cycle so it leaves a flip-flop.
   always @* begin
      next_rdata = `DATA_ZERO;
      case (acc_sel)
         `SEL_GEN:  next_rdata[7:0] = ~gen_on; // RULE2
         `SEL_HW:   next_rdata[7:0] = ~hw_on; // RULE3
         `SEL_STAT: begin
            next_rdata[`STAT_IRQ_LSB+7:`STAT_IRQ_LSB] = irq_on;
            next_rdata[`STAT_DMA_LSB+3:`STAT_DMA_LSB] = dma_on;
            next_rdata[`STAT_TEST_BIT] = hw_on[`HW_TEST]; // RULE15
            next_rdata[`STAT_PAIR_BIT] =
               (dma_on[`DMA_REQ2_SW] != dma_on[`DMA_ACK2_SW]) |
               (dma_on[`DMA_REQ3_SW] != dma_on[`DMA_ACK3_SW]); // RULE13
         end
         `SEL_CTRL: next_rdata = `DATA_ZERO;
         default:   next_rdata = `DATA_ZERO;
      endcase
   end

   // Read data only moves in a read setup cycle and then stands.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_PRDATA <= `DATA_ZERO;
      end else if (setup & ~I_PWRITE) begin
         O_PRDATA <= next_rdata;
      end
   end

   // Writing a one to the control word pulses the board reset.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         soft_reset <= 1'b0;
      end else begin
         soft_reset <= access & I_PWRITE & (acc_sel == `SEL_CTRL) &
                       I_PWDATA[`CTRL_SOFT_RST]; // RULE1
      end
   end

   // The button, the system reset and the software pulse reset the board.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_BOARD_RESET <= 1'b1;
      end else begin
         O_BOARD_RESET <= button | soft_reset; // RULE1
      end
   end

   // Setting outputs are active high for the switch in its on position.
   // On selects the narrow memory bus; off keeps the wide default.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_MEMORY_WIDTH_SELECT <= 1'b0;
      end else begin
         O_MEMORY_WIDTH_SELECT <= hw_on[`HW_MEM_WIDTH]; // RULE4
      end
   end

   // On tells the board that the bus clock runs in the slow range.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_BUS_CLOCK_RANGE_SELECT <= 1'b0;
      end else begin
         O_BUS_CLOCK_RANGE_SELECT <= hw_on[`HW_BUS_CLK]; // RULE5
      end
   end

   // On picks the lower multiplier; the pin follows the switch directly.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_PLL_MULTIPLIER_SELECT <= 1'b0;
      end else begin
         O_PLL_MULTIPLIER_SELECT <= hw_on[`HW_PLL_MUL]; // RULE6
      end
   end

   // Both kind bits off select the monitor program store.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_ROM_KIND_BIT0 <= 1'b0;
      end else begin
         O_ROM_KIND_BIT0 <= hw_on[`HW_ROM_KIND0]; // RULE7
      end
   end

   // The upper kind bit completes the two-bit code.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_ROM_KIND_BIT1 <= 1'b0;
      end else begin
         O_ROM_KIND_BIT1 <= hw_on[`HW_ROM_KIND1]; // RULE7
      end
   end

   // On maps both halves as one contiguous area.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_ROM_BANK_SPLIT_CONTROL <= 1'b0;
      end else begin
         O_ROM_BANK_SPLIT_CONTROL <= hw_on[`HW_ROM_SPLIT]; // RULE8
      end
   end

   // Bank choice only matters while the halves are split.
   // Forcing it low when contiguous keeps stale choices from leaking out.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_ROM_LOWER_HALF_SELECT <= 1'b0;
      end else begin
         O_ROM_LOWER_HALF_SELECT <= hw_on[`HW_ROM_LOWER] &
                                    ~hw_on[`HW_ROM_SPLIT]; // RULE9
      end
   end

   // The test switch raises this flag and status bit 12; no setting output reacts to it.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_CONFIG_UNSUPPORTED <= 1'b0;
      end else begin
         O_CONFIG_UNSUPPORTED <= hw_on[`HW_TEST]; // RULE15
      end
   end

   // Interrupt routing: a cut line is released, not driven low.
   // The far side must then see its own pull level on that line.
   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_irq
         always @(posedge I_CLK) begin
            if (I_RST) begin
               O_IRQ_INPUT[g]    <= 1'b0;
               O_IRQ_INPUT_OE[g] <= 1'b0;
            end else begin
               O_IRQ_INPUT[g]    <= I_IRQ_SOURCE[g] & irq_on[g]; // RULE10
               O_IRQ_INPUT_OE[g] <= irq_on[g]; // RULE10
            end
         end
      end
   endgenerate

   // DMA routing adds one clock of latency to each connected line.
   // A cut active-low line is held at its idle high level.
   function route_n;
      input level_n;
      input on;
      begin
         route_n = level_n | ~on;
      end
   endfunction

   // First request line from the extension bus.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_DMA_REQUEST_TWO_N    <= 1'b1;
         O_DMA_REQUEST_TWO_N_OE <= 1'b0;
      end else begin
         O_DMA_REQUEST_TWO_N    <= route_n(I_EXPANSION_DMA_REQUEST0_N,
                                           dma_on[`DMA_REQ2_SW]); // RULE12
         O_DMA_REQUEST_TWO_N_OE <= dma_on[`DMA_REQ2_SW]; // RULE12
      end
   end

   // Second request line from the extension bus.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_DMA_REQUEST_THREE_N    <= 1'b1;
         O_DMA_REQUEST_THREE_N_OE <= 1'b0;
      end else begin
         O_DMA_REQUEST_THREE_N    <= route_n(I_EXPANSION_DMA_REQUEST1_N,
                                             dma_on[`DMA_REQ3_SW]); // RULE12
         O_DMA_REQUEST_THREE_N_OE <= dma_on[`DMA_REQ3_SW]; // RULE12
      end
   end

   // Acknowledges travel back from the processor to the extension bus.
   always @(posedge I_CLK) begin
      if (I_RST) begin
         O_EXPANSION_DMA_ACK_N    <= `DMA_IDLE_N;
         O_EXPANSION_DMA_ACK_N_OE <= 2'h0;
      end else begin
         O_EXPANSION_DMA_ACK_N    <= {route_n(I_DMA_ACK_THREE_N,
                                              dma_on[`DMA_ACK3_SW]),
                                      route_n(I_DMA_ACK_TWO_N,
                                              dma_on[`DMA_ACK2_SW])}; // RULE12
         O_EXPANSION_DMA_ACK_N_OE <= {dma_on[`DMA_ACK3_SW],
                                      dma_on[`DMA_ACK2_SW]}; // RULE12
      end
   end
endmodule // board_config_switch_port

/* board_config_switch_port_properties.sv */
// Concurrent checks on the switch port block outputs.
`timescale 1ns/1ps
module board_config_switch_port_properties (
   input wire       I_CLK,
   input wire       I_RST,
   input wire       I_RESET_BUTTON,
   input wire       I_PSEL,
   input wire       I_PENABLE,
   input wire       O_PREADY,
   input wire       O_BOARD_RESET,
   input wire       O_MEMORY_WIDTH_SELECT,
   input wire       O_PLL_MULTIPLIER_SELECT,
   input wire       O_ROM_LOWER_HALF_SELECT,
   input wire       O_CONFIG_UNSUPPORTED,
   input wire       O_DMA_REQUEST_TWO_N_OE,
   input wire       O_DMA_REQUEST_THREE_N_OE,
   input wire [1:0] O_EXPANSION_DMA_ACK_N_OE,
   input wire [3:0] I_DMA_ROUTING_SWITCH_ON,
   input wire [7:0] I_HARDWARE_SETTING_SWITCH_ON,
   input wire [7:0] I_INTERRUPT_ROUTING_SWITCH_ON,
   input wire [7:0] I_IRQ_SOURCE,
   input wire [7:0] O_IRQ_INPUT,
   input wire [7:0] O_IRQ_INPUT_OE
);
   wire [7:0]  hw = I_HARDWARE_SETTING_SWITCH_ON;
   wire [7:0]  is = I_INTERRUPT_ROUTING_SWITCH_ON;
   wire [3:0]  ds = I_DMA_ROUTING_SWITCH_ON;
   wire [28:0] sw = {I_RESET_BUTTON, hw, is, ds, I_IRQ_SOURCE};
   reg  [2:0]  up;
   // Outputs other than O_PREADY are only judged once the synchronisers have flushed.
   always @(posedge I_CLK)
      up <= I_RST ? 3'h0 : (up[2] ? up : up + 3'h1);
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   sequence s_settled;
      (up[2] && $stable(sw))[*4];
   endsequence
   property p_mem; s_settled |-> O_MEMORY_WIDTH_SELECT == hw[0]; endproperty
   a_mem: assert property (p_mem)
      else $error("memory width wrong");
   property p_pll; s_settled |-> O_PLL_MULTIPLIER_SELECT == hw[2]; endproperty
   a_pll: assert property (p_pll)
      else $error("pll select wrong");
   property p_low;
      s_settled |-> O_ROM_LOWER_HALF_SELECT == (hw[7] & ~hw[6]);
   endproperty
   a_low: assert property (p_low)
      else $error("rom half wrong");
   property p_uns; s_settled |-> O_CONFIG_UNSUPPORTED == hw[3]; endproperty
   a_uns: assert property (p_uns)
      else $error("test flag wrong");
   property p_irq;
      s_settled |-> O_IRQ_INPUT_OE == is && O_IRQ_INPUT == (I_IRQ_SOURCE & is);
   endproperty
   a_irq: assert property (p_irq)
      else $error("irq routing wrong");
   property p_dma; s_settled |-> {O_DMA_REQUEST_THREE_N_OE,
      O_DMA_REQUEST_TWO_N_OE, O_EXPANSION_DMA_ACK_N_OE} ==
      {ds[2], ds[0], ds[3], ds[1]}; endproperty
   a_dma: assert property (p_dma)
      else $error("dma routing wrong");
   property p_btn; s_settled ##0 I_RESET_BUTTON |-> O_BOARD_RESET; endproperty
   a_btn: assert property (p_btn)
      else $error("button reset missing");
   property p_rdy; I_PSEL && I_PENABLE |-> O_PREADY; endproperty
   a_rdy: assert property (p_rdy)
      else $error("ready missing");
endmodule // board_config_switch_port_properties

/* cpu_core_model.sv */
// Processor-side model that sees routed lines and answers DMA requests.
`timescale 1ns/1ps
module cpu_core_model (
   input  wire       clk,
   input  wire [7:0] irq,
   input  wire [7:0] irq_oe,
   input  wire [1:0] req_n,
   input  wire [1:0] req_oe,
   output wire [7:0] irq_seen,
   output reg        ack2_n = 1'b1,
   output reg        ack3_n = 1'b1
);
   // A cut line floats, so it toggles rather than keep a stale level.
   reg [7:0] drift = 8'h5A;
   always @(posedge clk)
      drift <= ~drift;
   assign irq_seen = (irq & irq_oe) | (drift & ~irq_oe);
   // Cut requests are pulled up; the acknowledge trails by one cycle.
   always @(posedge clk) begin
      ack2_n <= req_oe[0] ? req_n[0] : 1'b1;
      ack3_n <= req_oe[1] ? req_n[1] : 1'b1;
   end
endmodule // cpu_core_model

/* board_config_switch_port_test.sv */
// Self-checking bench for the switch port block.
`timescale 1ns/1ps
`include "board_switch_regs.vh"
module board_config_switch_port_test;
   logic        clk, rst, btn, psel, pen, pwr, e0, e1, e;
   logic [7:0]  gen, hw, isw, src;
   logic [3:0]  dsw;
   logic [11:0] paddr;
   logic [31:0] pwd, rd, r, q;
   logic [63:0] cor [3];
   integer      errors, checked, seed, i, n;
   wire         rdy, err, brst, ack2, ack3;
   wire [1:0]   rq, rqoe, xack, xackoe;
   wire [7:0]   cfg, irq, irqoe, seen;
   wire [31:0]  prd;
   board_config_switch_port i_board_config_switch_port (
      .I_CLK(clk), .I_RST(rst), .I_RESET_BUTTON(btn),
      .I_GENERAL_SWITCH_ON(gen), .I_HARDWARE_SETTING_SWITCH_ON(hw),
      .I_INTERRUPT_ROUTING_SWITCH_ON(isw), .I_DMA_ROUTING_SWITCH_ON(dsw),
      .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(paddr),
      .I_PWDATA(pwd), .O_PREADY(rdy), .O_PSLVERR(err), .O_PRDATA(prd),
      .O_BOARD_RESET(brst), .O_MEMORY_WIDTH_SELECT(cfg[7]),
      .O_BUS_CLOCK_RANGE_SELECT(cfg[6]), .O_PLL_MULTIPLIER_SELECT(cfg[5]),
      .O_ROM_KIND_BIT0(cfg[4]), .O_ROM_KIND_BIT1(cfg[3]),
      .O_ROM_BANK_SPLIT_CONTROL(cfg[2]), .O_ROM_LOWER_HALF_SELECT(cfg[1]),
      .O_CONFIG_UNSUPPORTED(cfg[0]), .I_IRQ_SOURCE(src), .O_IRQ_INPUT(irq),
      .O_IRQ_INPUT_OE(irqoe), .I_EXPANSION_DMA_REQUEST0_N(e0),
      .I_EXPANSION_DMA_REQUEST1_N(e1), .O_DMA_REQUEST_TWO_N(rq[0]),
      .O_DMA_REQUEST_TWO_N_OE(rqoe[0]), .O_DMA_REQUEST_THREE_N(rq[1]),
      .O_DMA_REQUEST_THREE_N_OE(rqoe[1]), .I_DMA_ACK_TWO_N(ack2),
      .I_DMA_ACK_THREE_N(ack3), .O_EXPANSION_DMA_ACK_N(xack),
      .O_EXPANSION_DMA_ACK_N_OE(xackoe));
   cpu_core_model i_cpu_core_model (.clk(clk), .irq(irq), .irq_oe(irqoe),
      .req_n(rq), .req_oe(rqoe), .irq_seen(seen), .ack2_n(ack2),
      .ack3_n(ack3));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   function automatic logic [31:0] stat(logic [7:0] i, logic [3:0] d,
                                        logic [7:0] h);
      stat = {18'h0_0000, (d[0] ^ d[1]) | (d[2] ^ d[3]), h[3], d, i};
   endfunction
   function automatic logic [3:0] xdma(logic [3:0] d, logic a, logic b);
      logic r2, r3;
      r2 = d[0] ? a : 1'b1;
      r3 = d[2] ? b : 1'b1;
      xdma = {r3, r2, d[3] ? r3 : 1'b1, d[1] ? r2 : 1'b1};
   endfunction
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checked = checked + 1;
      if (got !== exp) begin
         errors = errors + 1;
         $display("mismatch at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n = n + 1;
      end while (rdy !== 1'b1 && n < 50);
      if (n >= 50)
         errors = errors + 1;
      rd = prd;
      e = err;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task drive(input logic [31:0] a, input logic [31:0] b);
      @(posedge clk);
      {dsw, isw, hw, gen} <= a[27:0];
      {e1, e0, src} <= b[9:0];
      repeat (5) @(posedge clk);
      apb(1'b0, `GEN_SW_OFS, 32'h0000_0000);
      chk(rd, {24'h00_0000, ~gen});
      apb(1'b0, `HW_SW_OFS, 32'h0000_0000);
      chk(rd, {24'h00_0000, ~hw});
      apb(1'b0, `ROUTE_STAT_OFS, 32'h0000_0000);
      chk(rd, stat(isw, dsw, hw));
      chk(cfg, {hw[0], hw[1], hw[2], hw[4], hw[5], hw[6], hw[7] & ~hw[6], hw[3]});
      chk(seen & isw, src & isw);
      chk({irqoe, rqoe, xackoe}, {isw, dsw[2], dsw[0], dsw[3], dsw[1]});
      chk({rq, xack}, xdma(dsw, e0, e1));
   endtask
   task wait_brst;
      for (n = 0; brst !== 1'b1 && n < 8; n = n + 1)
         @(posedge clk);
      chk(brst, 1'b1);
   endtask
   task test_done;
      $display("errors %0d checked %0d", errors, checked);
      if (errors == 0 && checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial begin
      #500000;
      errors = errors + 1;
      test_done;
   end
   initial begin
      {errors, checked, seed, rst, btn, psel, pen, pwr} = {64'd0, 32'd58, 5'h10};
      {paddr, pwd, gen, hw, isw, dsw, src, e0, e1} = 82'h0;
      cor = '{64'h0000_FF00_0000_03FF, 64'h06FF_8055_0000_00AA,
              64'h0F01_4000_0000_0100};
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 24; i = i + 1) begin
         r = $random(seed);
         q = $random(seed);
         r[11] = 1'b0;
         r[16] = 1'b1;
         {r[25], r[27]} = {r[24], r[26]};
         drive(r, q);
      end
      for (i = 0; i < 3; i = i + 1)
         drive(cor[i][63:32], cor[i][31:0]);
      apb(1'b1, `HW_SW_OFS, 32'hFFFF_FFFF);
      chk(e, 1'b1);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk(e, 1'b1);
      apb(1'b1, `BOARD_CTRL_OFS, 32'h0000_0001);
      wait_brst;
      btn <= 1'b1;
      wait_brst;
      btn <= 1'b0;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      chk({cfg, irqoe, rqoe, xackoe, rq, xack, brst}, 32'h0000_001F);
      rst <= 1'b0;
      drive(cor[1][63:32], cor[1][31:0]);
      test_done;
   end
endmodule // board_config_switch_port_test
bind board_config_switch_port board_config_switch_port_properties
   i_board_config_switch_port_properties (.*);
